// ==== logic/msim_cfg_if.sv ====
/*
  Carrier between the register file and the message builder: the
  programmed target and payload going out, event pulses coming back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps

interface msim_cfg_if;
  logic        enable;
  logic [31:0] target_low;
  logic [31:0] target_high;
  logic [15:0] payload;
  logic        busy;
  logic        ev_sent;
  logic        ev_drop;

  modport regs (output enable, target_low, target_high, payload,
                input  busy, ev_sent, ev_drop);
  modport msg  (input  enable, target_low, target_high, payload,
                output busy, ev_sent, ev_drop);
endinterface

// ==== logic/msim_evt.sv ====
/*
  Event status block: sticky status bits, an enable mask and a
  write-one-to-clear port, combined into one level interrupt.
  Assumes event pulses and clear strobes are synchronous to pclk.
*/
`timescale 1ns/10ps

module msim_evt #(
  parameter int unsigned W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] events,
  input  wire logic         clr_wr,
  input  wire logic         en_wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);

  logic [W-1:0] status_q;
  logic [W-1:0] enable_q;
  wire  [W-1:0] clr_mask = clr_wr ? wdata : {W{1'b0}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      enable_q <= '0;
    end else begin
      // New event beats a clear in the same cycle
      status_q <= (status_q & ~clr_mask) | events;
      if (en_wr) begin
        enable_q <= wdata;
      end
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq    = |(status_q & enable_q);

endmodule

// ==== logic/msim_msg.sv ====
/*
  Interrupt message builder: turns a request pulse into one memory
  write toward the upstream port, held until the link accepts it.
  Assumes the link side takes a write on mwr_valid and mwr_ready high.
*/
`timescale 1ns/10ps

module msim_msg
  import msim_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  msim_cfg_if.msg          cfg,
  input  wire logic        msg_req,
  input  wire logic        mwr_ready,
  output logic             mwr_valid,
  output logic [63:0]      mwr_addr,
  output logic             mwr_is64,
  output logic [31:0]      mwr_data
);

  logic        valid_q;
  logic [63:0] addr_q;
  logic        is64_q;
  logic [31:0] data_q;
  wire         accept  = msg_req && cfg.enable && !valid_q;
  wire         done    = valid_q && mwr_ready;
  wire         wide    = |cfg.target_high;
  wire  [63:0] addr_d  = wide ? {cfg.target_high, cfg.target_low}
                              : {32'h0000_0000, cfg.target_low};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      addr_q  <= 64'h0;
      is64_q  <= 1'b0;
      data_q  <= 32'h0;
    end else begin
      if (accept) begin
        valid_q <= 1'b1;
        addr_q  <= addr_d;
        is64_q  <= wide;
        data_q  <= {16'h0000, cfg.payload};
      end else if (done) begin
        valid_q <= 1'b0;
      end
    end
  end

  // Busy or disabled requests are lost; software sees the drop event
  assign cfg.busy    = valid_q;
  assign cfg.ev_sent = done;
  assign cfg.ev_drop = msg_req && !accept;
  assign mwr_valid   = valid_q;
  assign mwr_addr    = addr_q;
  assign mwr_is64    = is64_q;
  assign mwr_data    = data_q;

endmodule

// ==== logic/msim_pkg.sv ====
/*
  Constants for the interrupt message register block: register offsets,
  field positions, reset values and event bit positions.
  Assumes a 12-bit configuration byte address on an APB slave port.
*/
package msim_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] OFF_MSG_CTRL    = 12'h0d0;
  localparam logic [11:0] OFF_TARGET_LOW  = 12'h0d4;
  localparam logic [11:0] OFF_TARGET_HIGH = 12'h0d8;
  localparam logic [11:0] OFF_PAYLOAD     = 12'h0dc;
  localparam logic [11:0] OFF_EVT_STATUS  = 12'h0e0;
  localparam logic [11:0] OFF_EVT_ENABLE  = 12'h0e4;
  localparam logic [11:0] OFF_EVT_CLEAR   = 12'h0e8;
  localparam logic [11:0] OFF_SSID_HDR    = 12'h0f0;

  // Field positions
  localparam int unsigned TGT_LO_LSB   = 2;
  localparam int unsigned PAYLOAD_W    = 16;
  localparam int unsigned CAP_ID_LSB   = 0;
  localparam int unsigned NXT_LINK_LSB = 8;
  localparam int unsigned MSG_EN_BIT   = 16;
  localparam int unsigned MSG_BUSY_BIT = 0;

  // Reset and fixed values
  localparam logic [29:0] TGT_LO_RST   = 30'h0;
  localparam logic [31:0] TGT_HI_RST   = 32'h0;
  localparam logic [15:0] PAYLOAD_RST  = 16'h0;
  localparam logic [7:0]  SSID_CAP_ID  = 8'h0d;
  localparam logic [7:0]  NXT_LINK_RST = 8'h00;
  localparam logic        MSG_EN_RST   = 1'b0;

  // Event bits of status, enable and clear registers
  localparam int unsigned EVT_W    = 2;
  localparam int unsigned EVT_SENT = 0;
  localparam int unsigned EVT_DROP = 1;

endpackage

// ==== logic/msim_regs.sv ====
/*
  Interrupt message register block of a switch port: message target,
  payload, message enable, event status and the subsystem identity
  capability header, reached over APB; builds the message write.
  Assumes a zero-wait APB master on pclk and a link side that takes a
  message write on mwr_valid and mwr_ready.
*/
`timescale 1ns/10ps

module msim_regs
  import msim_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              msg_req,
  input  wire logic              mwr_ready,
  output logic                   mwr_valid,
  output logic      [63:0]       mwr_addr,
  output logic                   mwr_is64,
  output logic      [31:0]       mwr_data,
  output logic                   mwr_to_upstream,
  output logic                   irq
);

  msim_cfg_if cfg_bus ();

  // Register storage
  logic [29:0]          target_low_q;
  logic [31:0]          target_high_q;
  logic [15:0]          payload_q;
  logic [7:0]           next_link_q;
  logic                 msg_en_q;

  // Event block outputs
  logic [EVT_W-1:0]     evt_status;
  logic [EVT_W-1:0]     evt_enable;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // Address decode
  wire sel_ctrl   = hit(paddr, OFF_MSG_CTRL);
  wire sel_lo     = hit(paddr, OFF_TARGET_LOW);
  wire sel_hi     = hit(paddr, OFF_TARGET_HIGH);
  wire sel_pay    = hit(paddr, OFF_PAYLOAD);
  wire sel_stat   = hit(paddr, OFF_EVT_STATUS);
  wire sel_en     = hit(paddr, OFF_EVT_ENABLE);
  wire sel_clr    = hit(paddr, OFF_EVT_CLEAR);
  wire sel_ssid   = hit(paddr, OFF_SSID_HDR);
  wire mapped     = sel_ctrl | sel_lo | sel_hi | sel_pay | sel_stat | sel_en | sel_clr | sel_ssid;

  // Transfer qualifiers; the slave never inserts wait states
  wire access     = psel && penable;
  wire wr         = access && pwrite;
  wire rd         = access && !pwrite;
  wire wr_ctrl    = wr && sel_ctrl;
  wire wr_lo      = wr && sel_lo;
  wire wr_hi      = wr && sel_hi;
  wire wr_pay     = wr && sel_pay;
  wire wr_en      = wr && sel_en;
  wire wr_clr     = wr && sel_clr;
  wire wr_ssid    = wr && sel_ssid;

  // Read images; reserved positions are tied to zero
  wire [31:0] img_ctrl = {15'h0000, msg_en_q, 15'h0000, cfg_bus.busy};
  wire [31:0] img_lo   = {target_low_q, 2'b00};
  wire [31:0] img_hi   = target_high_q;
  wire [31:0] img_pay  = {16'h0000, payload_q};
  wire [31:0] img_stat = {{(32-EVT_W){1'b0}}, evt_status};
  wire [31:0] img_en   = {{(32-EVT_W){1'b0}}, evt_enable};
  wire [31:0] img_ssid = {16'h0000, next_link_q, SSID_CAP_ID};

  // Clear register is write-only and reads as zero
  wire [31:0] rd_mux =
      sel_ctrl ? img_ctrl :
      sel_lo   ? img_lo   :
      sel_hi   ? img_hi   :
      sel_pay  ? img_pay  :
      sel_stat ? img_stat :
      sel_en   ? img_en   :
      sel_ssid ? img_ssid : 32'h0000_0000;

  // Configuration storage, only documented fields take writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_low_q  <= TGT_LO_RST;
      target_high_q <= TGT_HI_RST;
      payload_q     <= PAYLOAD_RST;
      next_link_q   <= NXT_LINK_RST;
      msg_en_q      <= MSG_EN_RST;
    end else begin
      if (wr_lo) begin
        target_low_q <= pwdata[31:TGT_LO_LSB];
      end
      if (wr_hi) begin
        target_high_q <= pwdata;
      end
      if (wr_pay) begin
        payload_q <= pwdata[PAYLOAD_W-1:0];
      end
      if (wr_ssid) begin
        next_link_q <= pwdata[NXT_LINK_LSB +: 8];
      end
      if (wr_ctrl) begin
        msg_en_q <= pwdata[MSG_EN_BIT];
      end
    end
  end

  // Error is combinational so it lines up with the zero-wait pready
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = rd && mapped ? rd_mux : 32'h0000_0000;

  // Configuration handed to the message builder
  assign cfg_bus.enable      = msg_en_q;
  assign cfg_bus.target_low  = img_lo;
  assign cfg_bus.target_high = target_high_q;
  assign cfg_bus.payload     = payload_q;

  msim_msg u_msg (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (cfg_bus),
    .msg_req   (msg_req),
    .mwr_ready (mwr_ready),
    .mwr_valid (mwr_valid),
    .mwr_addr  (mwr_addr),
    .mwr_is64  (mwr_is64),
    .mwr_data  (mwr_data)
  );

  // Target routing is trusted; messages never go downstream
  assign mwr_to_upstream = 1'b1;

  wire [EVT_W-1:0] evt_pulses = {cfg_bus.ev_drop, cfg_bus.ev_sent};

  msim_evt #(
    .W (EVT_W)
  ) u_evt (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (evt_pulses),
    .clr_wr  (wr_clr),
    .en_wr   (wr_en),
    .wdata   (pwdata[EVT_W-1:0]),
    .status  (evt_status),
    .enable  (evt_enable),
    .irq     (irq)
  );

endmodule

// ==== sim/msim_properties.sv ====
/*
  Port checker for the interrupt message register block, bound to msim_regs.
  Assumes one clock, pclk, and the asynchronous active-low reset presetn.
*/
`timescale 1ns/10ps

module msim_properties
  import msim_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              msg_req,
  input wire logic              mwr_ready,
  input wire logic              mwr_valid,
  input wire logic [63:0]       mwr_addr,
  input wire logic              mwr_is64,
  input wire logic [31:0]       mwr_data,
  input wire logic              mwr_to_upstream
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hdr_rd;
  assign hdr_rd = psel && penable && !pwrite && paddr == OFF_SSID_HDR;

  property p_lo_align; mwr_valid |-> mwr_addr[1:0] == 2'h0; endproperty
  a_lo_align: assert property (p_lo_align)
    else $error("message address low bits set");
  property p_upstream; mwr_to_upstream == 1'b1; endproperty
  a_upstream: assert property (p_upstream)
    else $error("message not routed upstream");
  property p_wide; mwr_valid && mwr_is64 |-> mwr_addr[63:32] != 32'h0; endproperty
  a_wide: assert property (p_wide)
    else $error("wide message with zero high target");
  property p_narrow; mwr_valid && !mwr_is64 |-> mwr_addr[63:32] == 32'h0; endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow message with high address bits");
  property p_data; mwr_valid |-> mwr_data[31:16] == 16'h0; endproperty
  a_data: assert property (p_data)
    else $error("message data upper half not zero");
  property p_cap_id; hdr_rd |-> prdata[7:0] == 8'h0d; endproperty
  a_cap_id: assert property (p_cap_id)
    else $error("capability identifier wrong");
  property p_hdr_top; hdr_rd |-> prdata[31:16] == 16'h0; endproperty
  a_hdr_top: assert property (p_hdr_top)
    else $error("header reserved bits not zero");
  property p_start; $rose(mwr_valid) |-> $past(msg_req); endproperty
  a_start: assert property (p_start)
    else $error("message started without a request");
  property p_hold; mwr_valid && !mwr_ready |=> mwr_valid && $stable(mwr_addr) && $stable(mwr_data); endproperty
  a_hold: assert property (p_hold)
    else $error("pending message changed before acceptance");
  property p_once; mwr_valid && mwr_ready |=> !mwr_valid; endproperty
  a_once: assert property (p_once)
    else $error("message repeated after acceptance");
endmodule

bind msim_regs msim_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .msg_req, .mwr_ready, .mwr_valid, .mwr_addr, .mwr_is64, .mwr_data, .mwr_to_upstream);

// ==== sim/msim_root_model.sv ====
/*
  Root side model taking message writes, with a settable stall before ready.
  Assumes the writer holds valid and payload until ready is seen high.
*/
`timescale 1ns/10ps

module msim_root_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  stall,
  input  wire logic        mwr_valid,
  input  wire logic [63:0] mwr_addr,
  input  wire logic        mwr_is64,
  input  wire logic [31:0] mwr_data,
  output logic             mwr_ready,
  output logic [63:0]      got_addr,
  output logic             got_is64,
  output logic [31:0]      got_data,
  output logic [7:0]       got_cnt
);
  logic [3:0] wait_q;
  // Ready only after the stall, as a busy root would
  assign mwr_ready = mwr_valid && wait_q >= stall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      got_addr <= 64'h0;
      got_is64 <= 1'b0;
      got_data <= 32'h0;
      got_cnt <= 8'h0;
    end else if (mwr_valid && mwr_ready) begin
      wait_q <= 4'h0;
      got_addr <= mwr_addr;
      got_is64 <= mwr_is64;
      got_data <= mwr_data;
      got_cnt <= got_cnt + 8'h1;
    end else if (mwr_valid) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ==== sim/test_msim_regs.sv ====
/*
  Register and message tests for msim_regs over APB, with a root side model.
  Assumes the package offsets and a zero or more wait APB slave.
*/
`timescale 1ns/10ps

module test_msim_regs
  import msim_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        msg_req = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  stall = 4'h0;
  logic [31:0] prdata, mwr_data, got_data, rd_q;
  logic [63:0] mwr_addr, got_addr;
  logic        pready, pslverr, mwr_ready, mwr_valid, mwr_is64, mwr_to_upstream, irq, got_is64, err_q;
  logic [7:0]  got_cnt;
  int          failures = 0;
  int          n_tests = 0;

  always #5 pclk = ~pclk;

  msim_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .msg_req, .mwr_ready, .mwr_valid, .mwr_addr, .mwr_is64, .mwr_data, .mwr_to_upstream, .irq);
  msim_root_model root (.pclk, .presetn, .stall, .mwr_valid, .mwr_addr, .mwr_is64, .mwr_data,
    .mwr_ready, .got_addr, .got_is64, .got_data, .got_cnt);

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits as long as the slave needs; only the watchdog ends a stuck access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check($sformatf("register %h", a), {32'h0, rd_q}, {32'h0, exp});
  endtask

  // Waits for the root to count a write; a dropped request just times out here
  task automatic send_msg;
    logic [7:0] c0;
    int n;
    c0 = got_cnt;
    n = 0;
    msg_req <= 1'b1;
    @(posedge pclk);
    msg_req <= 1'b0;
    while (got_cnt == c0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    close_out;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFF_TARGET_LOW, 32'h0);
    rd_chk(OFF_TARGET_HIGH, 32'h0);
    rd_chk(OFF_PAYLOAD, 32'h0);
    rd_chk(OFF_MSG_CTRL, 32'h0);
    rd_chk(OFF_SSID_HDR, 32'h0000000d);
    check("mapped error", {63'h0, err_q}, 64'h0);
    apb(1'b1, OFF_TARGET_LOW, 32'hffffffff);
    rd_chk(OFF_TARGET_LOW, 32'hfffffffc);
    apb(1'b1, OFF_PAYLOAD, 32'hffffffff);
    rd_chk(OFF_PAYLOAD, 32'h0000ffff);
    apb(1'b1, OFF_SSID_HDR, 32'hffffffff);
    rd_chk(OFF_SSID_HDR, 32'h0000ff0d);
    apb(1'b0, 12'h0ec, 32'h0);
    check("unmapped error", {63'h0, err_q}, 64'h1);
    apb(1'b1, OFF_EVT_ENABLE, 32'h3);
    send_msg;
    check("sent while disabled", {56'h0, got_cnt}, 64'h0);
    rd_chk(OFF_EVT_STATUS, 32'h2);
    check("irq on drop", {63'h0, irq}, 64'h1);
    apb(1'b1, OFF_EVT_CLEAR, 32'h2);
    check("irq after clear", {63'h0, irq}, 64'h0);
    apb(1'b1, OFF_MSG_CTRL, 32'h00010000);
    apb(1'b1, OFF_TARGET_LOW, 32'hfee01230);
    apb(1'b1, OFF_PAYLOAD, 32'h0001abcd);
    for (int i = 0; i < 2; i++) begin
      stall <= i ? 4'h6 : 4'h0;
      apb(1'b1, OFF_TARGET_HIGH, 32'(i));
      send_msg;
      check("message count", {56'h0, got_cnt}, 64'(i + 1));
      check("message address", got_addr, {32'(i), 32'hfee01230});
      check("message width", {63'h0, got_is64}, 64'(i));
      check("message data", {32'h0, got_data}, 64'h0000abcd);
    end
    rd_chk(OFF_EVT_STATUS, 32'h1);
    check("route upstream", {63'h0, mwr_to_upstream}, 64'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFF_TARGET_HIGH, 32'h0);
    rd_chk(OFF_SSID_HDR, 32'h0000000d);
    close_out;
  end
endmodule
